// *** shared/tscfg_defs.svh ***
// tscfg_defs.svh: offsets, field positions, reset values and counts
// assumes 16-bit registers reached byte-wise, low byte first
`ifndef TSCFG_DEFS_SVH
`define TSCFG_DEFS_SVH

// register pointer values
`define TSCFG_OFS_STATUS   8'h02
`define TSCFG_OFS_PWR      8'h82
`define TSCFG_OFS_CHAN     8'h83
`define TSCFG_OFS_RATE     8'h84

// system_power_control fields (bit index within the 16-bit word)
`define TSCFG_B_ULP_RATE   0
`define TSCFG_B_PMODE      3
`define TSCFG_B_AUTO_DIS   5
`define TSCFG_B_ULP_EN     6
`define TSCFG_B_OSC        7
`define TSCFG_B_ACK_RST    8
`define TSCFG_B_SOFT_RST   9
`define TSCFG_B_REDO       10
`define TSCFG_B_COMMS_ATI  11
`define TSCFG_B_COMMS_NP   12
`define TSCFG_B_EVT_MODE   13
`define TSCFG_B_RSD_OFS    14
`define TSCFG_B_SLIDER     15

// status fields
`define TSCFG_B_ST_EVT     0
`define TSCFG_B_ST_BUSY    1
`define TSCFG_B_ST_RESET   7

// reset values; pulse bits never stored
`define TSCFG_RST_PWR      16'h4000
`define TSCFG_RST_CHAN     16'h00FF
`define TSCFG_RST_RATE     16'h0000
`define TSCFG_PULSE_MASK   16'h0700

// reseed offset and sampling-rate top value
`define TSCFG_RESEED_OFS   16'h0008
`define TSCFG_ULP_TOP      8'hFF

`endif

// *** shared/tscfg_pkg.sv ***
// tscfg_pkg: types shared by the serial front end and the register bank
// assumes the defs header is included where numbers are needed
package tscfg_pkg;
	// power modes in field order
	typedef enum logic [1:0] {PM_NP, PM_LP, PM_ULP, PM_HALT} tscfg_pmode_t;
	// serial slave states
	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} tscfg_st_t;
endpackage

// *** shared/tscfg_reg_if.sv ***
// tscfg_reg_if: byte strobes between serial slave and register bank
// assumes one clock domain, strobes one cycle wide
`timescale 1ns/1ps
`default_nettype none
interface tscfg_reg_if;
	logic       ptr_ld; // pointer byte received
	logic       wr_stb; // data byte received
	logic       rd_stb; // read byte taken
	logic [7:0] wbyte;  // received byte
	logic [7:0] rbyte;  // byte at pointer
	modport phy  (output ptr_ld, output wr_stb, output rd_stb, output wbyte, input rbyte);
	modport regs (input ptr_ld, input wr_stb, input rd_stb, input wbyte, output rbyte);
endinterface
`default_nettype wire

// *** logic/tscfg_i2c.sv ***
// tscfg_i2c: two-wire serial slave turning bus traffic into byte strobes
// assumes an external pull-up; sda is open drain, sda_oe high pulls low
`timescale 1ns/1ps
`default_nettype none
module tscfg_i2c import tscfg_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
	input  wire logic   sys_clk,
	input  wire logic   rst_n,
	input  wire logic   scl_i,
	input  wire logic   sda_i,
	output logic        sda_o,
	output logic        sda_oe,
	tscfg_reg_if.phy    rb
);
	logic [2:0] scl_q;  // sync pair plus edge history
	logic [2:0] sda_q;
	tscfg_st_t  st_q;   // protocol state
	logic [3:0] cnt_q;  // bits seen in this byte
	logic [7:0] sh_q;   // shift register, both directions
	logic       rw_q;   // read transfer
	logic       nack_q; // master refused more data
	logic       rise, fall, start, stop;

	// stage 0 is read only by stage 1
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= {scl_q[1:0], scl_i};
			sda_q <= {sda_q[1:0], sda_i};
		end
	end

	// edges judged on stages 1 and 2 only
	assign rise  = scl_q[1] & ~scl_q[2];
	assign fall  = ~scl_q[1] & scl_q[2];
	assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
	assign stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	assign sda_o = 1'b0; // open drain: only ever pulls low

	// protocol engine; start and stop win over bit traffic
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe <= 1'b0;
			rb.ptr_ld <= 1'b0;
			rb.wr_stb <= 1'b0;
			rb.rd_stb <= 1'b0;
			rb.wbyte <= 8'h00;
		end else begin
			rb.ptr_ld <= 1'b0;
			rb.wr_stb <= 1'b0;
			rb.rd_stb <= 1'b0;
			if (start) begin
				st_q <= ST_ADDR; // repeated start too
				cnt_q <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				st_q <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (rise) begin
				if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WR) begin
					sh_q <= {sh_q[6:0], sda_q[1]};
					cnt_q <= cnt_q + 4'h1;
				end else if (st_q == ST_RD) begin
					cnt_q <= cnt_q + 4'h1;
				end else if (st_q == ST_RD_ACK) begin
					nack_q <= sda_q[1];
				end
			end else if (fall) begin
				unique case (st_q)
					ST_IDLE: ;
					ST_ADDR: if (cnt_q == 4'h8) begin
						// only our address is acknowledged
						if (sh_q[7:1] == DEV_ADDR) begin
							st_q <= ST_ADDR_ACK;
							rw_q <= sh_q[0];
							sda_oe <= 1'b1;
						end else begin
							st_q <= ST_IDLE;
						end
					end
					ST_ADDR_ACK, ST_RD_ACK: begin
						cnt_q <= 4'h0;
						if (st_q == ST_RD_ACK && nack_q) begin
							st_q <= ST_IDLE;
							sda_oe <= 1'b0;
						end else if (rw_q) begin
							// fetch next byte, put its msb out
							st_q <= ST_RD;
							sh_q <= rb.rbyte;
							sda_oe <= ~rb.rbyte[7];
							rb.rd_stb <= 1'b1;
						end else begin
							st_q <= ST_PTR;
							sda_oe <= 1'b0;
						end
					end
					ST_RD: if (cnt_q == 4'h8) begin
						st_q <= ST_RD_ACK;
						sda_oe <= 1'b0;
					end else begin
						sh_q <= {sh_q[6:0], 1'b0};
						sda_oe <= ~sh_q[6];
					end
					ST_PTR, ST_WR: if (cnt_q == 4'h8) begin
						st_q <= (st_q == ST_PTR) ? ST_PTR_ACK : ST_WR_ACK;
						rb.ptr_ld <= (st_q == ST_PTR);
						rb.wr_stb <= (st_q == ST_WR);
						rb.wbyte <= sh_q;
						sda_oe <= 1'b1;
					end
					ST_PTR_ACK, ST_WR_ACK: begin
						st_q <= ST_WR;
						cnt_q <= 4'h0;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // tscfg_i2c
`default_nettype wire

// *** logic/tscfg_top.sv ***
// tscfg_top: power and comms configuration bank of the touch controller
// assumes measurement counts and auto power mode come from same-clock logic
`timescale 1ns/1ps
`default_nettype none
`include "tscfg_defs.svh"
module tscfg_top import tscfg_pkg::*; #(
	parameter int         TUNE_CYCLES = 16,   // length of a tuning run
	parameter logic [6:0] DEV_ADDR    = 7'h2A // arbitrary value
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic [127:0] meas_counts,
	input  wire logic [7:0]  mutual_ch,
	input  wire logic        event_in,
	input  wire logic [1:0]  auto_mode,
	input  wire logic [2:0]  lta_sel,
	output logic [15:0]      lta_out,
	output var tscfg_pmode_t power_mode,
	output logic [7:0]       ulp_rate,
	output logic             stream_on,
	output logic             event_on,
	output logic             tune_busy,
	output logic             soft_reset,
	output logic             event_pending,
	output logic [15:0]      pwr_ctl,
	output logic [15:0]      chan_ctl,
	output logic [15:0]      report_rates
);
	tscfg_reg_if  rb ();      // byte strobes from serial slave
	logic [7:0]   ptr_q;      // register pointer
	logic         idx_q;      // byte within word
	logic [15:0]  lta_q [8];  // long_term_average per channel
	logic [15:0]  tcnt_q;     // tuning cycle count
	logic         show_rst_q; // reset seen, not yet acknowledged
	logic         wr_pwr, wr_chan, wr_rate;
	logic         redo_p, ack_p, reseed_p, status_clr, tune_done;
	tscfg_pmode_t pm_d;
	logic         stream_d, event_d;
	logic [15:0]  rd_word, meas0;

	tscfg_i2c #(.DEV_ADDR(DEV_ADDR)) u_i2c (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.rb      (rb.phy)
	);

	// merge one byte into a word, high or low
	function automatic logic [15:0] merge(input logic [15:0] w, input logic hi, input logic [7:0] b);
		merge = hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	// reseed value with optional 8-count offset, saturating
	function automatic logic [15:0] seed(input logic [15:0] m, input logic mut, input logic ofs);
		if (!ofs)
			seed = m;
		else if (mut)
			seed = (m < `TSCFG_RESEED_OFS) ? 16'h0000 : m - `TSCFG_RESEED_OFS;
		else
			seed = (m > 16'hFFF7) ? 16'hFFFF : m + `TSCFG_RESEED_OFS;
	endfunction

	// sampling-rate code: doubles from 2, top code saturates
	function automatic logic [7:0] ulp_decode(input logic [2:0] c);
		ulp_decode = (c == 3'h7) ? `TSCFG_ULP_TOP : 8'(8'h02 << c);
	endfunction

	// write decode per register
	assign wr_pwr  = rb.wr_stb && ptr_q == `TSCFG_OFS_PWR;
	assign wr_chan = rb.wr_stb && ptr_q == `TSCFG_OFS_CHAN;
	assign wr_rate = rb.wr_stb && ptr_q == `TSCFG_OFS_RATE;
	// action bits are strobes; redo and ack read back as zero, reseed bits stay stored in chan_ctl
	assign redo_p   = wr_pwr && idx_q && rb.wbyte[`TSCFG_B_REDO - 8];
	assign ack_p    = wr_pwr && idx_q && rb.wbyte[`TSCFG_B_ACK_RST - 8];
	assign reseed_p = wr_chan && idx_q;
	// fetching status byte 0 clears the event
	assign status_clr = rb.rd_stb && ptr_q == `TSCFG_OFS_STATUS && !idx_q;
	assign tune_done  = tune_busy && tcnt_q == 16'(TUNE_CYCLES - 1);
	assign meas0      = meas_counts[15:0];

	// pointer and byte index; word pointer steps after the high byte
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ptr_q <= 8'h00;
			idx_q <= 1'b0;
		end else if (rb.ptr_ld) begin
			ptr_q <= rb.wbyte;
			idx_q <= 1'b0;
		end else if (rb.wr_stb || rb.rd_stb) begin
			idx_q <= ~idx_q;
			if (idx_q)
				ptr_q <= ptr_q + 8'h01;
		end
	end

	// configuration registers; writes elsewhere are dropped
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pwr_ctl <= `TSCFG_RST_PWR;
			chan_ctl <= `TSCFG_RST_CHAN;
			report_rates <= `TSCFG_RST_RATE;
		end else begin
			if (wr_pwr)
				pwr_ctl <= merge(pwr_ctl, idx_q, rb.wbyte) & ~`TSCFG_PULSE_MASK;
			if (wr_chan)
				chan_ctl <= merge(chan_ctl, idx_q, rb.wbyte);
			if (wr_rate)
				report_rates <= merge(report_rates, idx_q, rb.wbyte);
		end
	end

	// read mux; unmapped pointers read zero
	always_comb begin
		rd_word = 16'h0000;
		unique case (ptr_q)
			`TSCFG_OFS_STATUS: begin
				rd_word[`TSCFG_B_ST_EVT]   = event_pending;
				rd_word[`TSCFG_B_ST_BUSY]  = tune_busy;
				rd_word[`TSCFG_B_ST_RESET] = show_rst_q;
				rd_word[9:8]               = power_mode;
			end
			`TSCFG_OFS_PWR:  rd_word = pwr_ctl;
			`TSCFG_OFS_CHAN: rd_word = chan_ctl;
			`TSCFG_OFS_RATE: rd_word = report_rates;
			default: rd_word = 16'h0000;
		endcase
	end
	assign rb.rbyte = idx_q ? rd_word[15:8] : rd_word[7:0];

	// event flag: a new event beats a same-cycle clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			event_pending <= 1'b0;
		else if (event_in)
			event_pending <= 1'b1;
		else if (status_clr)
			event_pending <= 1'b0;
	end

	// reset indication and soft reset strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			show_rst_q <= 1'b1;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr_pwr && idx_q && rb.wbyte[`TSCFG_B_SOFT_RST - 8];
			if (ack_p)
				show_rst_q <= 1'b0;
		end
	end

	// tuning run; a request while busy is ignored
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tune_busy <= 1'b0;
			tcnt_q <= 16'h0000;
		end else if (tune_done) begin
			tune_busy <= 1'b0;
		end else if (tune_busy) begin
			tcnt_q <= tcnt_q + 16'h0001;
		end else if (redo_p) begin
			tune_busy <= 1'b1;
			tcnt_q <= 16'h0000;
		end
	end

	// averages seeded after tuning (enabled channels) or on reseed write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++)
				lta_q[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < 8; i++)
				if ((tune_done && chan_ctl[i]) || (reseed_p && rb.wbyte[i]))
					lta_q[i] <= seed(meas_counts[i*16 +: 16], mutual_ch[i],
						pwr_ctl[`TSCFG_B_RSD_OFS]);
		end
	end
	assign lta_out = lta_q[lta_sel];

	// forced mode only when auto switching is off
	assign pm_d = pwr_ctl[`TSCFG_B_AUTO_DIS] ? tscfg_pmode_t'(pwr_ctl[`TSCFG_B_PMODE +: 2])
		: tscfg_pmode_t'(auto_mode);

	// comms choice: tuning suspends reporting unless kept alive
	always_comb begin
		stream_d = 1'b0;
		event_d = 1'b0;
		if (tune_busy) begin
			stream_d = pwr_ctl[`TSCFG_B_COMMS_ATI];
		end else if (pm_d == PM_NP) begin
			// streaming in normal power when the option is set
			stream_d = pwr_ctl[`TSCFG_B_COMMS_NP] || !pwr_ctl[`TSCFG_B_EVT_MODE];
			event_d = !stream_d;
		end else if (pm_d != PM_HALT) begin
			event_d = pwr_ctl[`TSCFG_B_COMMS_NP] || pwr_ctl[`TSCFG_B_EVT_MODE];
			stream_d = !event_d;
		end
	end

	// registered mode, comms and rate outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_mode <= PM_NP;
			stream_on <= 1'b0;
			event_on <= 1'b0;
			ulp_rate <= 8'h02;
		end else begin
			power_mode <= pm_d;
			stream_on <= stream_d;
			event_on <= event_d;
			ulp_rate <= ulp_decode(pwr_ctl[`TSCFG_B_ULP_RATE +: 3]);
		end
	end

	AST_EVT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		event_in |=> event_pending) else $error("event flag not set");
	AST_EVT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		status_clr && !event_in |=> !event_pending) else $error("event flag not cleared");
	AST_SEED_SELF: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tune_done && chan_ctl[0] && !mutual_ch[0] && pwr_ctl[`TSCFG_B_RSD_OFS] && meas0 < 16'hFFF0
		|=> lta_q[0] == $past(meas0) + 16'h0008) else $error("self seed wrong");
	AST_SEED_MUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tune_done && chan_ctl[0] && mutual_ch[0] && pwr_ctl[`TSCFG_B_RSD_OFS] && meas0 > 16'h0008
		|=> lta_q[0] == $past(meas0) - 16'h0008) else $error("mutual seed wrong");
	AST_NP_STREAM: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!tune_busy && pm_d == PM_NP && pwr_ctl[`TSCFG_B_COMMS_NP] |=> stream_on && !event_on)
		else $error("no streaming in normal power");
	AST_LP_EVENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!tune_busy && pm_d == PM_LP && pwr_ctl[`TSCFG_B_COMMS_NP] |=> event_on && !stream_on)
		else $error("no event mode in low power");
	AST_TUNE_COMMS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tune_busy |=> stream_on == $past(pwr_ctl[`TSCFG_B_COMMS_ATI]) && !event_on)
		else $error("comms during tuning wrong");
	AST_ULP_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pwr_ctl[2:0] == 3'h7 ##1 pwr_ctl[2:0] == 3'h2 |=> ulp_rate == 8'h08 && $past(ulp_rate) == 8'hFF)
		else $error("sampling rate decode wrong");
	AST_PM_FORCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		pwr_ctl[`TSCFG_B_AUTO_DIS] && pwr_ctl[4:3] == 2'h3 |=> power_mode == PM_HALT && !stream_on && !event_on)
		else $error("forced halt ignored");
	AST_PM_AUTO: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!pwr_ctl[`TSCFG_B_AUTO_DIS] |=> power_mode == tscfg_pmode_t'($past(auto_mode)))
		else $error("auto mode not followed");
endmodule // tscfg_top
`default_nettype wire

// *** dv/tscfg_host_bfm.sv ***
// tscfg_host_bfm: two-wire bus master standing in for the host controller
// assumes a pull-up on sda outside; the device never stretches scl
`timescale 1ns/1ps
`default_nettype none
module tscfg_host_bfm #(
	parameter int H = 10 // clocks per scl half period, above the minimum of 4
) (
	input  wire logic sys_clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_low
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// every change lands just after a clock edge
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// start or repeated start; sda falls while scl is high
	task automatic start();
		hw(2);
		sda_low <= 1'b0;
		hw(H);
		scl <= 1'b1;
		hw(H);
		sda_low <= 1'b1;
		hw(H);
		scl <= 1'b0;
	endtask
	// stop; sda rises while scl is high
	task automatic stop();
		hw(2);
		sda_low <= 1'b1;
		hw(H);
		scl <= 1'b1;
		hw(H);
		sda_low <= 1'b0;
		hw(H);
	endtask
	// one bit; sda moves only while scl is low, so no false start
	task automatic bitx(input logic b, output logic r);
		hw(2);
		sda_low <= ~b;
		hw(H);
		scl <= 1'b1;
		hw(H);
		r = sda_w;
		scl <= 1'b0;
	endtask
	// byte out, msb first, then the device's acknowledge
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	// byte in; last byte gets a not-acknowledge
	task automatic byte_r(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, r);
			d = {d[6:0], r};
		end
		bitx(last, r);
	endtask
	// register write, low byte first
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v, output logic ok);
		logic [3:0] k;
		start();
		byte_w({a, 1'b0}, k[0]);
		byte_w(p, k[1]);
		byte_w(v[7:0], k[2]);
		byte_w(v[15:8], k[3]);
		stop();
		ok = &k;
	endtask
	// register read; a read of status byte 0 clears the event
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v, output logic ok);
		logic [2:0] k;
		start();
		byte_w({a, 1'b0}, k[0]);
		byte_w(p, k[1]);
		start();
		byte_w({a, 1'b1}, k[2]);
		byte_r(1'b0, v[7:0]);
		byte_r(1'b1, v[15:8]);
		stop();
		ok = &k;
	endtask
endmodule // tscfg_host_bfm
`default_nettype wire

// *** dv/tb_top.sv ***
// tb_top: self-checking bench for the power and comms configuration bank
// assumes the host model is the only bus master; sda has a pull-up
`timescale 1ns/1ps
`default_nettype none
module tb_top import tscfg_pkg::*;;
	localparam logic [6:0] ADDR = 7'h2A; // arbitrary value, same as the device
	logic         sys_clk, rst_n, scl, sda_low, sda_o, sda_oe, event_in, ok;
	logic         stream_on, event_on, tune_busy, soft_reset, event_pending;
	logic [127:0] meas;
	logic [15:0]  lta_out, pwr_ctl, chan_ctl, report_rates, v;
	logic [7:0]   mutual_ch, ulp_rate;
	logic [2:0]   lta_sel;
	logic [1:0]   auto_mode;
	tscfg_pmode_t power_mode;
	int           fail_count, check_count, cyc, sr_cnt;
	wire logic    sda_w = ~(sda_low | (sda_oe & ~sda_o)); // pull-up unless pulled
	// long tuning run so it is still busy when the write returns
	tscfg_top #(.TUNE_CYCLES(200), .DEV_ADDR(ADDR)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .meas_counts(meas), .mutual_ch(mutual_ch),
		.event_in(event_in), .auto_mode(auto_mode), .lta_sel(lta_sel), .lta_out(lta_out),
		.power_mode(power_mode), .ulp_rate(ulp_rate), .stream_on(stream_on), .event_on(event_on),
		.tune_busy(tune_busy), .soft_reset(soft_reset), .event_pending(event_pending),
		.pwr_ctl(pwr_ctl), .chan_ctl(chan_ctl), .report_rates(report_rates));
	tscfg_host_bfm u_host (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
	// 4 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// hang guard and soft reset pulse count
	always @(posedge sys_clk) begin
		cyc++;
		if (soft_reset === 1'b1) sr_cnt++;
		if (cyc == 80000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (fail_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		u_host.wr_reg(ADDR, p, d, ok);
		chk("write ack", 16'h0001, {15'h0, ok});
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		u_host.rd_reg(ADDR, p, d, ok);
		chk("read ack", 16'h0001, {15'h0, ok});
	endtask
	// seed value of a channel, worked out from its counts
	function automatic logic [15:0] exp_lta(input int i, input logic off);
		logic [15:0] m;
		m = meas[16*i +: 16];
		if (!off) return m;
		if (mutual_ch[i]) return (m < 16'h0008) ? 16'h0000 : m - 16'h0008;
		return (m > 16'hFFF7) ? 16'hFFFF : m + 16'h0008;
	endfunction
	task automatic chk_lta(input logic off);
		for (int i = 0; i < 4; i++) begin
			lta_sel <= 3'(i);
			@(posedge sys_clk);
			chk("lta_out", exp_lta(i, off), lta_out);
		end
	endtask
	// bounded wait for the tuning run to end
	task automatic wait_tune();
		for (int n = 0; n < 400 && tune_busy !== 1'b0; n++) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic t_reset();
		chk("pwr_ctl", 16'h4000, pwr_ctl);
		chk("chan_ctl", 16'h00FF, chan_ctl);
		chk("report_rates", 16'h0000, report_rates);
		chk("ulp_rate", 16'h0002, {8'h00, ulp_rate});
		rd(8'h82, v);
		chk("pwr read", 16'h4000, v);
	endtask
	// event flag set, then cleared by a status read
	task automatic t_event();
		event_in <= 1'b1;
		@(posedge sys_clk);
		event_in <= 1'b0;
		@(posedge sys_clk);
		chk("pending", 16'h0001, {15'h0, event_pending});
		rd(8'h02, v);
		chk("status", 16'h0081, v);
		chk("pending", 16'h0000, {15'h0, event_pending});
	endtask
	// read-only, unmapped, strobe bits, foreign address
	task automatic t_misc();
		wr(8'h84, 16'hA55A);
		chk("report_rates", 16'hA55A, report_rates);
		wr(8'h82, 16'h4100);
		u_host.wr_reg(ADDR, 8'h02, 16'hFFFF, ok);
		rd(8'h02, v);
		chk("status ro", 16'h0000, v);
		u_host.rd_reg(ADDR, 8'h90, v, ok);
		chk("unmapped", 16'h0000, v);
		wr(8'h82, 16'h4200);
		chk("soft reset", 16'h0001, 16'(sr_cnt));
		chk("pwr_ctl", 16'h4000, pwr_ctl);
		u_host.wr_reg(7'h11, 8'h82, 16'h0000, ok);
		chk("foreign ack", 16'h0000, {15'h0, ok});
	endtask
	task automatic t_ulp();
		for (int c = 0; c < 8; c++) begin
			wr(8'h82, 16'h4020 | 16'(c));
			chk("ulp_rate", (c == 7) ? 16'h00FF : 16'h0002 << c, {8'h00, ulp_rate});
		end
		// top code straight back to a low code in one write
		wr(8'h82, 16'h4022);
		chk("ulp_rate", 16'h0008, {8'h00, ulp_rate});
	endtask
	task automatic t_pmode();
		auto_mode <= 2'h2;
		wr(8'h82, 16'h0018);
		chk("auto mode", 16'h0002, {14'h0, power_mode});
		for (int m = 0; m < 4; m++) begin
			wr(8'h82, 16'h0020 | 16'(m << 3));
			chk("forced mode", 16'(m), {14'h0, power_mode});
		end
	endtask
	// reporting style in normal, low power and halt, then during tuning
	task automatic t_comms();
		logic [15:0] cw [6] = '{16'h2020, 16'h3020, 16'h0020, 16'h3028, 16'h0028, 16'h3038};
		logic [1:0]  ce [6] = '{2'b01, 2'b10, 2'b10, 2'b01, 2'b10, 2'b00};
		for (int i = 0; i < 6; i++) begin
			wr(8'h82, cw[i]);
			chk("stream/event", {14'h0, ce[i]}, {14'h0, stream_on, event_on});
		end
		wr(8'h82, 16'h2C20);
		chk("tune stream", 16'h0003, {14'h0, tune_busy, stream_on});
		wait_tune();
		chk("after tune", 16'h0001, {14'h0, stream_on, event_on});
		chk_lta(1'b0);
		wr(8'h82, 16'h2420);
		chk("tune silent", 16'h0004, {13'h0, tune_busy, stream_on, event_on});
		wait_tune();
	endtask
	task automatic t_reseed();
		wr(8'h82, 16'h4020);
		wr(8'h83, 16'h0FFF);
		chk_lta(1'b1);
		// tuning with the offset on, channel 0 self then mutual
		wr(8'h82, 16'h4420);
		wait_tune();
		chk_lta(1'b1);
		mutual_ch <= 8'h05;
		wr(8'h82, 16'h4420);
		wait_tune();
		chk_lta(1'b1);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		event_in = 1'b0;
		auto_mode = 2'h0;
		lta_sel = 3'h0;
		mutual_ch = 8'h0A;
		meas = {64'h0, 16'h2000, 16'hFFFC, 16'h0004, 16'h1000};
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_event();
		t_misc();
		t_ulp();
		t_pmode();
		t_comms();
		t_reseed();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
